// >>> hdl/txci_consts.svh
// Purpose: shared constants of the transmit client interface
// Assumes: included by bare name
// Notes:   definitions only
`ifndef TXCI_CONSTS_SVH
`define TXCI_CONSTS_SVH
`define TXCI_DATA_W        8
`define TXCI_PTIME_W       16
`define TXCI_STAT_W        31
`define TXCI_FIFO_DEPTH    16
`define TXCI_STAT_UNDERRUN 5
`define TXCI_STAT_PAUSE    6
`define TXCI_STAT_VLAN     7
`define TXCI_STAT_LEN_LO   8
`define TXCI_STAT_LEN_HI   21
`define TXCI_LEN_W         14
`define TXCI_CLK_MHZ       100
`define TXCI_START_DLY_NS  20
`define TXCI_START_DLY_CYC ((`TXCI_START_DLY_NS * `TXCI_CLK_MHZ + 999) / 1000)
`define TXCI_PAUSE_LEN     60
`define TXCI_DIV_100M      10
`define TXCI_DIV_10M       100
`define TXCI_RST_PTIME     16'h0000
`endif

// >>> hdl/txci_pkg.sv
// Purpose: types of the transmit client interface
// Assumes: constants come from txci_consts.svh
// Notes:   one-hot state codes
package txci_pkg;
  typedef enum logic [4:0] {
    TXCI_IDLE  = 5'h01,
    TXCI_WAIT  = 5'h02,
    TXCI_DATA  = 5'h04,
    TXCI_PAUSE = 5'h08,
    TXCI_DONE  = 5'h10
  } txci_state_type;
  typedef enum logic [1:0] {
    TXCI_SPD_1G   = 2'h0,
    TXCI_SPD_100M = 2'h1,
    TXCI_SPD_10M  = 2'h2
  } txci_speed_type;
endpackage

// >>> hdl/txci_if.sv
// Purpose: link between the MAC transmit side and the client FIFO
// Assumes: all signals on core_clk
// Notes:   no clocking block
`timescale 1ns/100ps
`include "txci_consts.svh"
interface txci_if;
  logic [`TXCI_DATA_W-1:0]  fifo_data;
  logic                     fifo_avail;
  logic                     fifo_eof;
  logic                     fifo_empty;
  logic                     fifo_ctrl;
  logic [`TXCI_PTIME_W-1:0] pause_time;
  logic                     pause_req;
  logic                     mac_read;
  logic                     stat_en;
  logic [`TXCI_STAT_W-1:0]  stat_vec;
  logic                     tx_done;
  modport mac (
    input  fifo_data, fifo_avail, fifo_eof, fifo_empty, fifo_ctrl, pause_time, pause_req,
    output mac_read, stat_en, stat_vec, tx_done
  );
  modport client (
    output fifo_data, fifo_avail, fifo_eof, fifo_empty, fifo_ctrl, pause_time, pause_req,
    input  mac_read, stat_en, stat_vec, tx_done
  );
endinterface

// >>> hdl/txci_fifo.sv
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: one clock, no read latency: head word read combinationally from memory
// Notes:   depth must be a power of two
`timescale 1ns/100ps
module txci_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,  // clock
  input  wire logic             nrst,      // async reset, low
  input  wire logic [WIDTH-1:0] in_data,   // write data
  input  wire logic             in_valid,  // write valid
  output logic                  in_ready,  // not full
  output logic      [WIDTH-1:0] out_data,  // head word
  output logic                  out_valid, // not empty
  input  wire logic             out_ready  // pop
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("txci_fifo: DEPTH must be power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wp_ff;
  logic [AW:0]      rp_ff;
  logic [AW:0]      nxt_wp;
  logic [AW:0]      nxt_rp;
  logic             push;
  logic             pop;
  always_comb begin
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    nxt_wp = wp_ff + (AW+1)'(push);
    nxt_rp = rp_ff + (AW+1)'(pop);
  end
  assign in_ready  = (wp_ff[AW-1:0] != rp_ff[AW-1:0]) || (wp_ff[AW] == rp_ff[AW]);
  assign out_valid = (wp_ff != rp_ff);
  assign out_data  = mem_ff[rp_ff[AW-1:0]];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

// >>> hdl/txci_client.sv
// Purpose: client end: frame FIFO feeding the MAC transmit side
// Assumes: user pushes bytes with an end-of-frame mark
// Notes:   frame-available raised once a whole frame is stored
`timescale 1ns/100ps
`include "txci_consts.svh"
module txci_client
  import txci_pkg::*;
#(
  parameter int DEPTH = `TXCI_FIFO_DEPTH
) (
  input  wire logic                     core_clk,   // clock
  input  wire logic                     nrst,       // async reset, low
  input  wire logic [`TXCI_DATA_W-1:0]  usr_data,   // byte to send
  input  wire logic                     usr_eof,    // last byte of frame
  input  wire logic                     usr_ctrl,   // frame is control
  input  wire logic                     usr_valid,  // byte valid
  output logic                          usr_ready,  // fifo can take byte
  input  wire logic                     usr_preq,   // pause request
  input  wire logic [`TXCI_PTIME_W-1:0] usr_ptime,  // pause time
  output logic                          usr_done,   // frame sent ok
  output logic                          usr_stat_en,// stats valid
  output logic [`TXCI_STAT_W-1:0]       usr_stat,   // stats vector
  txci_if.client                        lnk         // link to MAC
);
  localparam int CW = $clog2(DEPTH+1);
  logic [`TXCI_DATA_W+1:0] head;
  logic                  head_valid;
  logic                  push_eof;
  logic                  pop_eof;
  logic [CW-1:0]         frames_ff;
  logic [CW-1:0]         nxt_frames;
  logic [`TXCI_DATA_W:0] rd_ff;
  logic [`TXCI_DATA_W:0] nxt_rd;
  logic                  done_ff;
  logic                  sten_ff;
  logic [`TXCI_STAT_W-1:0] stat_ff;
  logic                  preq_ff;
  logic [`TXCI_PTIME_W-1:0] ptime_ff;
  // control flag travels with every byte, so each frame keeps its own
  txci_fifo #(.WIDTH(`TXCI_DATA_W+2), .DEPTH(DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_data   ({usr_ctrl, usr_eof, usr_data}),
    .in_valid  (usr_valid),
    .in_ready  (usr_ready),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (lnk.mac_read)
  );
  always_comb begin
    push_eof   = usr_valid && usr_ready && usr_eof;
    pop_eof    = lnk.mac_read && head_valid && head[`TXCI_DATA_W];
    nxt_frames = frames_ff + CW'(push_eof) - CW'(pop_eof);
    nxt_rd     = (lnk.mac_read && head_valid) ? head[`TXCI_DATA_W:0] : rd_ff;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frames_ff <= '0;
      rd_ff     <= '0;
      done_ff   <= 1'b0;
      sten_ff   <= 1'b0;
      stat_ff   <= '0;
      preq_ff   <= 1'b0;
      ptime_ff  <= `TXCI_RST_PTIME;
    end else begin
      frames_ff <= nxt_frames;
      rd_ff     <= nxt_rd;
      done_ff   <= lnk.tx_done;
      sten_ff   <= lnk.stat_en;
      stat_ff   <= lnk.stat_en ? lnk.stat_vec : stat_ff;
      preq_ff   <= usr_preq;
      ptime_ff  <= usr_ptime;
    end
  end
  // one-cycle read latency, byte and eof registered
  assign lnk.fifo_data  = rd_ff[`TXCI_DATA_W-1:0];
  assign lnk.fifo_eof   = rd_ff[`TXCI_DATA_W];
  assign lnk.fifo_empty = !head_valid;
  assign lnk.fifo_avail = (frames_ff != '0);
  assign lnk.fifo_ctrl  = (frames_ff != '0) && head[`TXCI_DATA_W+1];
  assign lnk.pause_req  = preq_ff;
  assign lnk.pause_time = ptime_ff;
  assign usr_done       = done_ff;
  assign usr_stat_en    = sten_ff;
  assign usr_stat       = stat_ff;
endmodule

// >>> hdl/txci_mac.sv
// Purpose: MAC end of the transmit client FIFO interface
// Assumes: client keeps data synchronous to core_clk
// Notes:   media side is reduced to byte, valid, error, pause and pause-time outputs
// Behaviour
// - client presents FIFO byte on 8-bit bus
// - frame-available starts transmission after short delay
// - client derives frame-available from count of stored end-of-frame bytes
// - end-of-frame marks only the final byte
// - empty while reading flags under-run on error
// - pause frame carries client pause time
// - pause request sends pause; time held valid
// - control-frame input qualified by frame-available
// - statistics enable only with valid vector
// - read request raised only while not empty
// - read request drives FIFO read enable directly
// - client inputs synchronous to byte clock
// - clock enable gates progress; divided by speed
// - statistics carry byte count in 21:8
// - transmit done pulses one cycle on success
`timescale 1ns/100ps
`include "txci_consts.svh"
module txci_mac
  import txci_pkg::*;
#(
  parameter int START_DLY = `TXCI_START_DLY_CYC,
  parameter int PAUSE_LEN = `TXCI_PAUSE_LEN
) (
  input  wire logic                    core_clk,  // clock
  input  wire logic                    nrst,      // async reset, low
  input  wire logic                    serial_en, // use divided enable
  input  wire txci_speed_type          speed,     // line rate select
  output logic [`TXCI_DATA_W-1:0]      med_data,  // media byte
  output logic                         med_valid, // media byte valid
  output logic                         med_err,   // media error
  output logic [`TXCI_PTIME_W-1:0]     med_ptime, // pause time sent
  output logic                         med_pause, // pause frame active
  txci_if.mac                          lnk        // link to client
);
  initial begin
    if (START_DLY < 1 || START_DLY > 255 || PAUSE_LEN < 1 || PAUSE_LEN > 255) begin
      $error("txci_mac: bad delay parameters");
    end
  end
  // ====================================================================
  // clock enable divider
  logic [6:0] div_ff;
  logic [6:0] nxt_div;
  logic [6:0] div_top;
  logic       cen;
  always_comb begin
    case (speed)
      TXCI_SPD_100M: div_top = 7'(`TXCI_DIV_100M - 1);
      TXCI_SPD_10M:  div_top = 7'(`TXCI_DIV_10M - 1);
      default:       div_top = 7'h00;
    endcase
    nxt_div = (div_ff >= div_top) ? 7'h00 : div_ff + 7'h01;
    cen     = !serial_en || (div_ff == 7'h00);
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 7'h00;
    end else begin
      div_ff <= nxt_div;
    end
  end
  // ====================================================================
  // transmit state machine
  txci_state_type                st_ff, nxt_st;
  logic [7:0]                    cnt_ff, nxt_cnt;
  logic                          rd_ff, nxt_rd;
  logic                          smp_ff, nxt_smp;
  logic [`TXCI_LEN_W-1:0]        len_ff, nxt_len;
  logic                          urun_ff, nxt_urun;
  logic                          ctrl_ff, nxt_ctrl;
  logic [`TXCI_PTIME_W-1:0]      pt_ff, nxt_pt;
  logic [`TXCI_DATA_W-1:0]       dat_ff, nxt_dat;
  logic                          val_ff, nxt_val;
  logic                          err_ff, nxt_err;
  logic                          pau_ff, nxt_pau;
  logic                          pfr_ff, nxt_pfr;
  logic                          done_ff, nxt_done;
  logic                          sten_ff, nxt_sten;
  logic [`TXCI_STAT_W-1:0]       stat_ff, nxt_stat;
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_rd   = 1'b0;
    nxt_smp  = rd_ff;                                // byte valid cycle after read
    nxt_len  = len_ff;
    nxt_urun = urun_ff;
    nxt_ctrl = ctrl_ff;
    nxt_pt   = pt_ff;
    nxt_dat  = dat_ff;
    nxt_val  = 1'b0;
    nxt_err  = 1'b0;
    nxt_pau  = pau_ff;
    nxt_pfr  = pfr_ff;
    nxt_done = 1'b0;
    nxt_sten = 1'b0;
    nxt_stat = stat_ff;
    if (smp_ff) begin
      // byte from read one cycle earlier
      nxt_dat = lnk.fifo_data;
      nxt_val = 1'b1;
      nxt_len = len_ff + `TXCI_LEN_W'(1);
    end
    case (st_ff)
      TXCI_IDLE: begin
        if (cen && lnk.pause_req) begin
          nxt_pt  = lnk.pause_time;
          nxt_cnt = 8'h00;
          nxt_pau = 1'b1;
          nxt_pfr = 1'b1;
          nxt_st  = TXCI_PAUSE;
        end else if (cen && lnk.fifo_avail) begin
          nxt_ctrl = lnk.fifo_ctrl;
          nxt_cnt  = 8'h00;
          nxt_len  = '0;
          nxt_urun = 1'b0;
          nxt_pfr  = 1'b0;
          nxt_st   = TXCI_WAIT;
        end
      end
      TXCI_WAIT: begin
        if (cen) begin
          nxt_cnt = cnt_ff + 8'h01;
          if (32'(cnt_ff) + 1 >= START_DLY) begin
            nxt_st = TXCI_DATA;
          end
        end
      end
      TXCI_DATA: begin
        if (smp_ff && lnk.fifo_eof) begin
          nxt_st = TXCI_DONE;
        end else if (rd_ff) begin
          nxt_st = TXCI_DATA;                        // waiting for sampled byte
        end else if (cen && !smp_ff) begin
          if (!lnk.fifo_empty) begin
            nxt_rd  = 1'b1;
          end else begin
            nxt_urun = 1'b1;
            nxt_err  = 1'b1;
            nxt_st   = TXCI_DONE;
          end
        end
      end
      TXCI_PAUSE: begin
        if (cen) begin
          nxt_cnt = cnt_ff + 8'h01;
          if (32'(cnt_ff) + 1 >= PAUSE_LEN) begin
            nxt_pau = 1'b0;
            nxt_len = `TXCI_LEN_W'(PAUSE_LEN);
            nxt_urun = 1'b0;
            nxt_st  = TXCI_DONE;
          end
        end
      end
      TXCI_DONE: begin
        nxt_stat = '0;
        nxt_stat[`TXCI_STAT_LEN_HI:`TXCI_STAT_LEN_LO] = len_ff;
        nxt_stat[`TXCI_STAT_UNDERRUN] = urun_ff;
        nxt_stat[`TXCI_STAT_PAUSE]    = pfr_ff;
        nxt_sten = 1'b1;
        nxt_done = !urun_ff;
        nxt_pau  = 1'b0;
        nxt_st   = TXCI_IDLE;
      end
      default: begin
        nxt_st = TXCI_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff   <= TXCI_IDLE;
      cnt_ff  <= 8'h00;
      rd_ff   <= 1'b0;
      smp_ff  <= 1'b0;
      len_ff  <= '0;
      urun_ff <= 1'b0;
      ctrl_ff <= 1'b0;
      pt_ff   <= `TXCI_RST_PTIME;
      dat_ff  <= '0;
      val_ff  <= 1'b0;
      err_ff  <= 1'b0;
      pau_ff  <= 1'b0;
      pfr_ff  <= 1'b0;
      done_ff <= 1'b0;
      sten_ff <= 1'b0;
      stat_ff <= '0;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      rd_ff   <= nxt_rd;
      smp_ff  <= nxt_smp;
      len_ff  <= nxt_len;
      urun_ff <= nxt_urun;
      ctrl_ff <= nxt_ctrl;
      pt_ff   <= nxt_pt;
      dat_ff  <= nxt_dat;
      val_ff  <= nxt_val;
      err_ff  <= nxt_err;
      pau_ff  <= nxt_pau;
      pfr_ff  <= nxt_pfr;
      done_ff <= nxt_done;
      sten_ff <= nxt_sten;
      stat_ff <= nxt_stat;
    end
  end
  assign lnk.mac_read = rd_ff;
  assign lnk.stat_en  = sten_ff;
  assign lnk.stat_vec = stat_ff;
  assign lnk.tx_done  = done_ff;
  assign med_data     = dat_ff;
  assign med_valid    = val_ff;
  assign med_err      = err_ff;
  assign med_ptime    = pt_ff;
  assign med_pause    = pau_ff;
endmodule

// >>> testbench/txci_checker.sv
// Purpose: link checks for the MAC and client ends
// Assumes: one clock domain
// Notes:   watches the first link only
`timescale 1ns/100ps
module txci_checker (
  input wire logic        core_clk,   // clock
  input wire logic        nrst,       // reset, low
  input wire logic [7:0]  fifo_data,  // byte
  input wire logic        fifo_avail, // frame stored
  input wire logic        fifo_eof,   // last byte
  input wire logic        fifo_empty, // empty
  input wire logic        fifo_ctrl,  // control frame
  input wire logic [15:0] pause_time, // pause time
  input wire logic        pause_req,  // pause request
  input wire logic        mac_read,   // read pulse
  input wire logic        stat_en,    // stats valid
  input wire logic [30:0] stat_vec,   // stats
  input wire logic        tx_done     // frame done
);
  // ====
  // bytes read since last stats
  logic [13:0] cnt_ff;
  logic [13:0] nxt_cnt;
  always_comb begin
    nxt_cnt = stat_en ? 14'h0 : cnt_ff + {13'h0, mac_read};
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) cnt_ff <= 14'h0;
    else cnt_ff <= nxt_cnt;
  end
  // ====
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence seq_last_byte;
    mac_read ##1 fifo_eof;
  endsequence
  sequence seq_frame_ready;
    $rose(fifo_avail) && !pause_req;
  endsequence
  a_read_not_empty: assert property (mac_read |-> !fifo_empty)
    else $error("read while empty");
  a_read_spaced: assert property (mac_read |=> !mac_read)
    else $error("reads back to back");
  a_frame_starts: assert property (seq_frame_ready |-> ##[1:1000] mac_read)
    else $error("frame never read");
  a_eof_done: assert property (seq_last_byte |-> ##[2:30] (tx_done && stat_en))
    else $error("no done after last byte");
  a_done_ok: assert property (tx_done |-> (stat_en || $past(stat_en)) && !stat_vec[5])
    else $error("done without clean stats");
  a_stat_single: assert property (stat_en |=> !stat_en)
    else $error("stats strobe too long");
  a_stat_len: assert property (stat_en && !stat_vec[6] |-> stat_vec[21:8] == cnt_ff)
    else $error("byte count wrong");
  a_ctrl_qual: assert property (!fifo_avail |-> !fifo_ctrl)
    else $error("control flag without frame");
endmodule

// >>> testbench/tb.sv
// Purpose: bench for MAC and client ends on one link
// Assumes: core_clk at 100 MHz
// Notes:   second link has a faulty client driven here
`timescale 1ns/100ps
`include "txci_consts.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb import txci_pkg::*; ();
  localparam int PLEN = `TXCI_PAUSE_LEN;
  logic           core_clk, nrst = 1'b0, serial_en = 1'b0, usr_valid = 1'b0;
  logic           usr_eof = 1'b0, usr_ctrl = 1'b0, usr_preq = 1'b0, usr_ready;
  logic           usr_done, usr_stat_en, med_valid, med_err, med_pause, m2_err;
  logic [7:0]     usr_data = 8'h00, med_data, g, x;
  logic [15:0]    usr_ptime = 16'h0000, med_ptime, pt_seen;
  logic [30:0]    usr_stat, st_last, st_pause, m2_st;
  txci_speed_type speed = TXCI_SPD_1G;
  int             failures, checks_done, cyc, last_v, min_gap, k;
  int             n_done, n_err, n_pause, m2_errs, m2_dones;
  logic [7:0]     got_q[$], exp_q[$];
  txci_if lnk();
  txci_if lnk2();
  txci_client txci_client_i (.core_clk, .nrst, .usr_data, .usr_eof, .usr_ctrl, .usr_valid,
    .usr_ready, .usr_preq, .usr_ptime, .usr_done, .usr_stat_en, .usr_stat, .lnk);
  txci_mac #(.PAUSE_LEN(PLEN)) txci_mac_i (.core_clk, .nrst, .serial_en, .speed, .med_data,
    .med_valid, .med_err, .med_ptime, .med_pause, .lnk);
  txci_mac #(.PAUSE_LEN(PLEN)) txci_mac_i2 (.core_clk, .nrst, .serial_en(1'b0),
    .speed(TXCI_SPD_1G), .med_data(), .med_valid(), .med_err(m2_err), .med_ptime(),
    .med_pause(), .lnk(lnk2));
  txci_checker txci_checker_i (.core_clk, .nrst, .fifo_data(lnk.fifo_data),
    .fifo_avail(lnk.fifo_avail), .fifo_eof(lnk.fifo_eof), .fifo_empty(lnk.fifo_empty),
    .fifo_ctrl(lnk.fifo_ctrl), .pause_time(lnk.pause_time), .pause_req(lnk.pause_req),
    .mac_read(lnk.mac_read), .stat_en(lnk.stat_en), .stat_vec(lnk.stat_vec),
    .tx_done(lnk.tx_done));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ====
  // monitor of both media sides
  always @(posedge core_clk) begin
    cyc++;
    if (med_valid === 1'b1) begin
      got_q.push_back(med_data);
      min_gap = (cyc - last_v < min_gap) ? cyc - last_v : min_gap;
      last_v = cyc;
    end
    if (med_err !== 1'b0) n_err++;
    if (usr_done === 1'b1) n_done++;
    if (usr_stat_en === 1'b1) st_last = usr_stat;
    if (usr_stat_en === 1'b1 && usr_stat[6] === 1'b1) st_pause = usr_stat;
    if (med_pause === 1'b1) n_pause++;
    if (med_pause === 1'b1) pt_seen = med_ptime;
    if (m2_err !== 1'b0) m2_errs++;
    if (lnk2.tx_done === 1'b1) m2_dones++;
    if (lnk2.stat_en === 1'b1) m2_st = lnk2.stat_vec;
  end
  // ====
  // tasks
  task automatic print_verdict;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic push(input logic [7:0] d, input logic e, input logic c);
    @(negedge core_clk);
    usr_data = d;
    usr_eof = e;
    usr_ctrl = c;
    usr_valid = 1'b1;
    for (k = 0; k < 200 && usr_ready !== 1'b1; k++) @(negedge core_clk);
    @(posedge core_clk);
  endtask
  task automatic frame(input int n, input logic [7:0] b, input logic c);
    for (int i = 0; i < n; i++) begin
      push(b + 8'(i), 1'(i == n - 1), c);
      exp_q.push_back(b + 8'(i));
    end
    @(negedge core_clk);
    usr_valid = 1'b0;
  endtask
  task automatic check_out(input int t, input logic [13:0] len);
    for (k = 0; k < 5000 && n_done < t; k++) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    `CHK(n_done, t)
    `CHK(got_q.size(), exp_q.size())
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      g = got_q.pop_front();
      x = exp_q.pop_front();
      `CHK(g, x)
    end
    `CHK(st_last[21:8], len)
    `CHK(n_err, 0)
    got_q.delete();
    exp_q.delete();
    n_done = 0;
  endtask
  task automatic t_reset;
    `CHK(lnk.fifo_empty, 1'b1)
    `CHK(lnk.mac_read, 1'b0)
  endtask
  task automatic t_b2b;
    frame(1, 8'h3C, 1'b1);
    for (k = 0; k < 50 && lnk.fifo_avail !== 1'b1; k++) @(negedge core_clk);
    `CHK(lnk.fifo_ctrl, 1'b1)
    frame(4, 8'hF0, 1'b0);
    for (k = 0; k < 100 && n_done < 1; k++) @(negedge core_clk);
    `CHK(lnk.fifo_ctrl, 1'b0)
    check_out(2, 14'h0004);
  endtask
  task automatic t_fill;
    frame(`TXCI_FIFO_DEPTH, 8'h80, 1'b0);
    `CHK(usr_ready, 1'b0)
    check_out(1, 14'(`TXCI_FIFO_DEPTH));
    `CHK(lnk.fifo_empty, 1'b1)
  endtask
  task automatic t_pause;
    n_pause = 0;
    @(negedge core_clk);
    usr_ptime = 16'hA5C3;
    usr_preq = 1'b1;
    frame(2, 8'h70, 1'b0);
    usr_preq = 1'b0;
    check_out(2, 14'h0002);
    `CHK(n_pause, PLEN)
    `CHK(pt_seen, 16'hA5C3)
    `CHK(st_pause[21:8], 14'(PLEN))
  endtask
  task automatic t_serial;
    @(negedge core_clk);
    serial_en = 1'b1;
    speed = TXCI_SPD_100M;
    min_gap = 100000;
    frame(3, 8'hC0, 1'b0);
    check_out(1, 14'h0003);
    `CHK(min_gap >= `TXCI_DIV_100M, 1'b1)
    serial_en = 1'b0;
    speed = TXCI_SPD_1G;
  endtask
  task automatic t_underrun;
    @(negedge core_clk);
    lnk2.fifo_empty = 1'b0;
    lnk2.fifo_avail = 1'b1;
    for (k = 0; k < 50 && lnk2.mac_read !== 1'b1; k++) @(negedge core_clk);
    lnk2.fifo_data = 8'h5A;
    lnk2.fifo_empty = 1'b1;
    lnk2.fifo_avail = 1'b0;
    @(negedge core_clk);
    lnk2.fifo_data = 8'hA5;
    for (k = 0; k < 50 && m2_errs == 0; k++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    `CHK(m2_errs, 1)
    `CHK(m2_st[5], 1'b1)
    `CHK(m2_dones, 0)
  endtask
  // ====
  // main sequence and watchdog
  initial begin
    lnk2.fifo_data = 8'h00;
    lnk2.fifo_avail = 1'b0;
    lnk2.fifo_eof = 1'b0;
    lnk2.fifo_empty = 1'b1;
    lnk2.fifo_ctrl = 1'b0;
    lnk2.pause_time = 16'h0000;
    lnk2.pause_req = 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    t_reset;
    t_b2b;
    t_fill;
    t_pause;
    t_serial;
    t_underrun;
    print_verdict;
  end
  initial begin
    #300000;
    failures++;
    print_verdict;
  end
endmodule
